// ==== src/cfr_pkg.sv ====
// constants and types shared by the flag and register-pointer block
// assumes a byte-wide system-register port driven by the core datapath
package cfr_pkg;

	// ==========================================================
	// system register addresses
	localparam logic [7:0] CFR_ADDR_INT_CTRL   = 8'hE6; // interrupt control, low nibble only
	localparam logic [7:0] CFR_ADDR_FLAGS      = 8'hE7; // status_flags_reg
	localparam logic [7:0] CFR_ADDR_LOW_PTR    = 8'hE8; // low_block_pointer_reg
	localparam logic [7:0] CFR_ADDR_HIGH_PTR   = 8'hE9; // high_block_pointer_reg
	localparam logic [3:0] CFR_GROUP_HIDDEN    = 4'hD;  // group reachable only indirectly

	// ==========================================================
	// status flag bit positions
	localparam int CFR_FLAG_CARRY   = 7;
	localparam int CFR_FLAG_ZERO    = 6;
	localparam int CFR_FLAG_SIGN    = 5;
	localparam int CFR_FLAG_OVFL    = 4;
	localparam int CFR_FLAG_DECADJ  = 3;
	localparam int CFR_FLAG_HALF    = 2;
	localparam int CFR_FLAG_RSVD    = 1;
	localparam int CFR_FLAG_SPACE   = 0;

	// ==========================================================
	// interrupt control field positions
	localparam int CFR_ICR_NEST     = 3; // arbitration_nesting
	localparam int CFR_ICR_PRIO_MSB = 2; // current priority 2:0

	// ==========================================================
	// pointer register layout
	localparam int CFR_PTR_BLK_MSB  = 7; // block_number 7:3
	localparam int CFR_PTR_BLK_LSB  = 3;
	localparam int CFR_PTR_MODE     = 2; // pointer_mode_twin

	// ==========================================================
	// reset values and depths
	localparam logic [7:0] CFR_FLAGS_RESET = 8'h00;
	localparam logic [2:0] CFR_PRIO_RESET  = 3'h7; // lowest level
	localparam logic       CFR_NEST_RESET  = 1'b0;
	localparam logic [4:0] CFR_BLK_RESET   = 5'h00;
	localparam int         CFR_NEST_DEPTH  = 7;    // saved copies allowed

	// ==========================================================
	// datapath operation classes
	typedef enum logic [2:0] {
		CFR_OP_NONE  = 3'b000, // no flag effect
		CFR_OP_ARITH = 3'b001, // add, sub, compare
		CFR_OP_SHIFT = 3'b010, // shift, rotate, swap, decimal adjust
		CFR_OP_MULDV = 3'b011, // multiply, divide
		CFR_OP_LOGIC = 3'b100, // logical, inc/dec, test
		CFR_OP_UNUSED5 = 3'b101,
		CFR_OP_UNUSED6 = 3'b110,
		CFR_OP_UNUSED7 = 3'b111
	} cfr_op_t;

	// pointer-setting instructions
	typedef enum logic [1:0] {
		CFR_PTR_NONE  = 2'b00,
		CFR_PTR_SINGLE = 2'b01, // single 16-register set
		CFR_PTR_LOW   = 2'b10, // set_low_twin_pointer
		CFR_PTR_HIGH  = 2'b11  // set_high_twin_pointer
	} cfr_ptr_cmd_t;

endpackage : cfr_pkg

// ==== src/cfr_block_pointer.sv ====
// one working-register block pointer: block number plus twin-mode bit
// assumes loads are already decoded by the parent, one at a time
`timescale 1ns/100ps
module cfr_block_pointer (
	input  wire logic       ref_clk,     // core clock
	input  wire logic       rst,         // synchronous reset, high
	input  wire logic       load_blk,    // load block number
	input  wire logic [4:0] blk_in,      // new block number
	input  wire logic       load_mode,   // load mode bit
	input  wire logic       mode_in,     // new mode bit
	output logic      [4:0] block_number, // held block number
	output logic            pointer_mode_twin, // held mode bit
	output logic      [7:0] reg_image    // register read image
);
	import cfr_pkg::*;

	// ==========================================================
	// block number store, 0 to 31
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			block_number <= CFR_BLK_RESET;
		end else if (load_blk) begin
			block_number <= blk_in;
		end
	end

	// mode bit store
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pointer_mode_twin <= 1'b0;
		end else if (load_mode) begin
			pointer_mode_twin <= mode_in;
		end
	end

	// low two bits are hardwired to zero on read
	assign reg_image = {block_number, pointer_mode_twin, 2'b00};

endmodule : cfr_block_pointer

// ==== src/cfr_prio_stack.sv ====
// saved-priority store: last-in first-out of preempted priority levels
// assumes the parent never pushes when full nor pops when empty
`timescale 1ns/100ps
module cfr_prio_stack (
	input  wire logic       ref_clk,  // core clock
	input  wire logic       rst,      // synchronous reset, high
	input  wire logic       push,     // save a level
	input  wire logic [2:0] push_val, // level being saved
	input  wire logic       pop,      // recall the newest level
	output logic      [2:0] top_val,  // newest saved level
	output logic      [2:0] depth     // number of saved levels
);
	import cfr_pkg::*;

	logic [2:0] slot [CFR_NEST_DEPTH]; // saved levels

	// ==========================================================
	// storage; only the written slot changes
	always_ff @(posedge ref_clk) begin
		if (push && (depth < 3'(CFR_NEST_DEPTH))) begin
			slot[depth] <= push_val;
		end
	end

	// fill count; a push and pop together cancel
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			depth <= 3'h0;
		end else if (push && !pop && (depth < 3'(CFR_NEST_DEPTH))) begin
			depth <= depth + 3'h1;
		end else if (pop && !push && (depth != 3'h0)) begin
			depth <= depth - 3'h1;
		end
	end

	// empty stack reads back the reset level
	assign top_val = (depth == 3'h0) ? CFR_PRIO_RESET : slot[depth - 3'h1];

endmodule : cfr_prio_stack

// ==== src/cfr_core_regs.sv ====
// status flags, interrupt priority field and working-register pointers
// assumes the datapath drives one-cycle strobes synchronous to ref_clk
// and handles the system stack memory itself
//
// Operation
// - arbitration bit: 0 concurrent, 1 nested
// - three-bit priority, 000 highest, 111 lowest
// - requests compared against current priority level
// - preempted priority saved, restored on return
// - flags pushed on entry, restored on return
// - nested mode holds up to seven copies
// - flags reset zero; fixed bit order
// - carry from bit 7 or bit 15
// - carry set, clear, invert instructions
// - zero flag on zero accumulator result
// - sign copies result top bit
// - overflow on signed range error
// - decimal-adjust flag records add or subtract
// - half carry from bit 3
// - data/program space flag, set and cleared
// - register file seen as 32 blocks
// - twin set instructions set mode bit
// - single mode rounds block down to even
// - twin: r0-r7 low, r8-r15 high pointer
// - pointer: block 7:3, mode 2, zeros
// - hidden group rejected on direct addressing
`timescale 1ns/100ps
module cfr_core_regs (
	input  wire logic                 ref_clk,        // core clock, 100 MHz
	input  wire logic                 rst,            // synchronous reset, high
	// system register port
	input  wire logic [7:0]           reg_addr,       // direct register address
	input  wire logic                 reg_wr,         // write strobe
	input  wire logic                 reg_rd,         // read strobe
	input  wire logic [7:0]           reg_wdata,      // write data
	output logic      [7:0]           reg_rdata,      // registered read data
	output logic                      reg_hit,        // address is held here
	output logic                      reg_reject,     // direct access refused
	// flag updates from the datapath
	input  wire logic                 alu_valid,      // result strobe
	input  wire cfr_pkg::cfr_op_t     alu_op,         // operation class
	input  wire logic                 alu_word,       // word operation
	input  wire logic [15:0]          alu_result,     // accumulator result
	input  wire logic                 alu_carry_b7,   // carry out of bit 7
	input  wire logic                 alu_carry_b15,  // carry out of bit 15
	input  wire logic                 alu_half,       // carry/borrow at bit 3
	input  wire logic                 alu_overflow,   // signed range error
	input  wire logic                 alu_sub,        // operation subtracted
	input  wire logic                 carry_set,      // force carry high
	input  wire logic                 carry_clr,      // force carry low
	input  wire logic                 carry_inv,      // invert carry
	input  wire logic                 space_data,     // select data space
	input  wire logic                 space_prog,     // select program space
	output logic      [7:0]           status_flags,   // flag register
	output logic                      memory_space_select, // data pointers in use
	// interrupt sequencing
	input  wire logic                 irq_req,        // request present
	input  wire logic [2:0]           irq_level,      // request priority
	output logic                      irq_preempt,    // request may be taken
	input  wire logic                 int_enter,      // entry strobe
	input  wire logic                 int_return,     // return strobe
	input  wire logic [7:0]           stack_pop_flags, // flags read back from stack
	output logic                      stack_push,     // push flags now
	output logic      [7:0]           stack_push_flags, // flags to push
	output logic      [2:0]           current_prio,   // running priority
	output logic                      arbitration_nesting, // nested mode
	output logic      [2:0]           nest_depth,     // saved copies held
	// working-register pointers
	input  wire cfr_pkg::cfr_ptr_cmd_t ptr_cmd,       // pointer-setting instruction
	input  wire logic [4:0]           ptr_block,      // block operand
	input  wire logic [3:0]           wr_index,       // working register r0-r15
	output logic      [7:0]           wr_phys_addr,   // mapped register address
	output logic                      pointer_mode_twin // twin mode active
);
	import cfr_pkg::*;

	// ==========================================================
	// declarations
	logic       wr_int;          // write to interrupt control
	logic       wr_flags;        // write to flag register
	logic       wr_low;          // write to low pointer
	logic       wr_high;         // write to high pointer
	logic [7:0] next_flags;      // flag value after this cycle
	logic [7:0] alu_flags;       // flags as the datapath result sets them
	logic       res_zero;        // accumulator result is zero
	logic       res_sign;        // accumulator result top bit
	logic       res_carry;       // carry out of the top bit
	logic       take_entry;      // interrupt entry accepted
	logic       take_return;     // interrupt return accepted
	logic [2:0] saved_top;       // newest saved priority
	logic [4:0] low_blk;         // low pointer block number
	logic [4:0] high_blk;        // high pointer block number
	logic       low_twin;        // low pointer mode copy
	logic       high_twin;       // high pointer mode copy
	logic [7:0] low_image;       // low pointer read image
	logic [7:0] high_image;      // high pointer read image
	logic       load_low_blk;    // low block load
	logic       load_high_blk;   // high block load
	logic       load_mode;       // mode load to both pointers
	logic       next_mode;       // mode value loaded
	logic [4:0] next_low_blk;    // low block value loaded
	logic [4:0] next_high_blk;   // high block value loaded
	logic [4:0] map_blk;         // block chosen for the index

	// ==========================================================
	// register decode
	// group D may only be reached through pointers, never directly
	always_comb begin
		reg_reject = (reg_wr || reg_rd) && (reg_addr[7:4] == CFR_GROUP_HIDDEN);
		reg_hit    = (reg_addr == CFR_ADDR_INT_CTRL) || (reg_addr == CFR_ADDR_FLAGS) ||
		             (reg_addr == CFR_ADDR_LOW_PTR) || (reg_addr == CFR_ADDR_HIGH_PTR);
		wr_int     = reg_wr && (reg_addr == CFR_ADDR_INT_CTRL);
		wr_flags   = reg_wr && (reg_addr == CFR_ADDR_FLAGS);
		wr_low     = reg_wr && (reg_addr == CFR_ADDR_LOW_PTR);
		wr_high    = reg_wr && (reg_addr == CFR_ADDR_HIGH_PTR);
	end

	// read data registered one cycle after the strobe; misses read zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				CFR_ADDR_INT_CTRL: begin // upper control bits live elsewhere
					reg_rdata <= {4'h0, arbitration_nesting, current_prio};
				end
				CFR_ADDR_FLAGS: begin
					reg_rdata <= status_flags;
				end
				CFR_ADDR_LOW_PTR: begin
					reg_rdata <= low_image;
				end
				CFR_ADDR_HIGH_PTR: begin
					reg_rdata <= high_image;
				end
				default: begin // not held by this block
					reg_rdata <= 8'h00;
				end
			endcase
		end
	end

	// ==========================================================
	// arbitration mode and current priority
	// software writes the mode bit directly
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			arbitration_nesting <= CFR_NEST_RESET;
		end else if (wr_int) begin
			arbitration_nesting <= reg_wdata[CFR_ICR_NEST];
		end
	end

	// lower number is higher priority; a nested slot must remain free
	always_comb begin
		if (arbitration_nesting) begin // nested: preempt a running routine
			irq_preempt = irq_req && (irq_level < current_prio) &&
			              (nest_depth < 3'(CFR_NEST_DEPTH));
		end else begin // concurrent: only when no routine is running
			irq_preempt = irq_req && (irq_level < current_prio) &&
			              (nest_depth == 3'h0);
		end
	end

	assign take_entry  = int_enter && (nest_depth < 3'(CFR_NEST_DEPTH));
	assign take_return = int_return && (nest_depth != 3'h0);

	// hardware entry and return win over a software write in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			current_prio <= CFR_PRIO_RESET;
		end else if (take_entry) begin
			current_prio <= irq_level;
		end else if (take_return) begin
			current_prio <= saved_top;
		end else if (wr_int) begin
			current_prio <= reg_wdata[CFR_ICR_PRIO_MSB:0];
		end
	end

	// preempted level kept until the matching return
	cfr_prio_stack u_saved_priority_reg (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.push     (take_entry),
		.push_val (current_prio),
		.pop      (take_return),
		.top_val  (saved_top),
		.depth    (nest_depth)
	);

	// ==========================================================
	// system stack hand-off
	// the pushed copy is the value before entry changes anything
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stack_push       <= 1'b0;
			stack_push_flags <= 8'h00;
		end else begin
			stack_push <= take_entry;
			if (take_entry) begin
				stack_push_flags <= status_flags;
			end
		end
	end

	// ==========================================================
	// flag results from the datapath
	// width select picks bit 7 or bit 15 for carry and sign
	always_comb begin
		res_zero  = alu_word ? (alu_result == 16'h0000) : (alu_result[7:0] == 8'h00);
		res_sign  = alu_word ? alu_result[15] : alu_result[7];
		res_carry = alu_word ? alu_carry_b15 : alu_carry_b7;
		alu_flags = status_flags;
		unique case (alu_op)
			CFR_OP_ARITH: begin
				alu_flags[CFR_FLAG_CARRY] = res_carry;
				alu_flags[CFR_FLAG_ZERO]  = res_zero;
				alu_flags[CFR_FLAG_SIGN]  = res_sign;
				alu_flags[CFR_FLAG_OVFL]  = alu_overflow;
				if (!alu_word) begin // BCD helpers only for byte add/sub
					alu_flags[CFR_FLAG_DECADJ] = alu_sub;
					alu_flags[CFR_FLAG_HALF]   = alu_half;
				end
			end
			CFR_OP_SHIFT, CFR_OP_MULDV: begin
				alu_flags[CFR_FLAG_CARRY] = res_carry;
				alu_flags[CFR_FLAG_ZERO]  = res_zero;
				alu_flags[CFR_FLAG_SIGN]  = res_sign;
				alu_flags[CFR_FLAG_OVFL]  = alu_overflow;
			end
			CFR_OP_LOGIC: begin // carry untouched
				alu_flags[CFR_FLAG_ZERO] = res_zero;
				alu_flags[CFR_FLAG_SIGN] = res_sign;
				alu_flags[CFR_FLAG_OVFL] = alu_overflow;
			end
			default: begin // no-flag or undefined class
				alu_flags = status_flags;
			end
		endcase
	end

	// ==========================================================
	// flag next value
	// priority: return restore, software write, then carry and space ops over the datapath result
	always_comb begin
		next_flags = status_flags;
		if (take_return) begin
			next_flags = stack_pop_flags;
		end else if (wr_flags) begin
			next_flags = reg_wdata;
		end else begin
			if (alu_valid) begin
				next_flags = alu_flags;
			end
			if (carry_set) begin
				next_flags[CFR_FLAG_CARRY] = 1'b1;
			end else if (carry_clr) begin
				next_flags[CFR_FLAG_CARRY] = 1'b0;
			end else if (carry_inv) begin
				next_flags[CFR_FLAG_CARRY] = ~status_flags[CFR_FLAG_CARRY];
			end
			if (space_data) begin
				next_flags[CFR_FLAG_SPACE] = 1'b1;
			end else if (space_prog) begin
				next_flags[CFR_FLAG_SPACE] = 1'b0;
			end
		end
		next_flags[CFR_FLAG_RSVD] = 1'b0;
	end

	// flag register, zero after reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_flags <= CFR_FLAGS_RESET;
		end else begin
			status_flags <= next_flags;
		end
	end

	// data accesses follow data pointers only while the space flag is set
	assign memory_space_select = status_flags[CFR_FLAG_SPACE];

	// ==========================================================
	// pointer loads
	// instruction loads win over a software write in the same cycle
	always_comb begin
		load_low_blk  = 1'b0;
		load_high_blk = 1'b0;
		load_mode     = 1'b0;
		next_mode     = low_twin;
		next_low_blk  = reg_wdata[CFR_PTR_BLK_MSB:CFR_PTR_BLK_LSB];
		next_high_blk = reg_wdata[CFR_PTR_BLK_MSB:CFR_PTR_BLK_LSB];
		unique case (ptr_cmd)
			CFR_PTR_SINGLE: begin
				load_low_blk = 1'b1;
				next_low_blk = ptr_block; // kept as given, rounded at use
				load_mode    = 1'b1;
				next_mode    = 1'b0;
			end
			CFR_PTR_LOW: begin
				load_low_blk = 1'b1;
				next_low_blk = ptr_block;
				load_mode    = 1'b1;
				next_mode    = 1'b1;
			end
			CFR_PTR_HIGH: begin
				load_high_blk = 1'b1;
				next_high_blk = ptr_block;
				load_mode     = 1'b1;
				next_mode     = 1'b1;
			end
			CFR_PTR_NONE: begin // software writes only
				load_low_blk  = wr_low;
				load_high_blk = wr_high;
				load_mode     = wr_low || wr_high;
				next_mode     = reg_wdata[CFR_PTR_MODE];
			end
		endcase
	end

	// both pointers carry the same mode bit so either reads back the mode
	cfr_block_pointer u_low_block_pointer (
		.ref_clk           (ref_clk),
		.rst               (rst),
		.load_blk          (load_low_blk),
		.blk_in            (next_low_blk),
		.load_mode         (load_mode),
		.mode_in           (next_mode),
		.block_number      (low_blk),
		.pointer_mode_twin (low_twin),
		.reg_image         (low_image)
	);

	// high pointer: meaningful in twin mode only, otherwise reserved
	cfr_block_pointer u_high_block_pointer (
		.ref_clk           (ref_clk),
		.rst               (rst),
		.load_blk          (load_high_blk),
		.blk_in            (next_high_blk),
		.load_mode         (load_mode),
		.mode_in           (next_mode),
		.block_number      (high_blk),
		.pointer_mode_twin (high_twin),
		.reg_image         (high_image)
	);

	assign pointer_mode_twin = low_twin;

	// ==========================================================
	// working-register mapping over 32 eight-register blocks
	// single mode uses the even block at or below the low pointer
	always_comb begin
		if (low_twin) begin
			map_blk      = wr_index[3] ? high_blk : low_blk;
			wr_phys_addr = {map_blk, wr_index[2:0]};
		end else begin
			map_blk      = {low_blk[4:1], 1'b0};
			wr_phys_addr = {map_blk[4:1], wr_index};
		end
	end

endmodule : cfr_core_regs

// ==== testbench/cfr_core_regs_assertions.sv ====
// ==========================================================
// port-level checks for the flag and pointer block
// assumes it is bound onto cfr_core_regs by implicit names
`timescale 1ns/100ps
module cfr_core_regs_assertions
	import cfr_pkg::*;
(
	input wire logic                  ref_clk, rst, reg_wr, reg_rd, reg_reject, // clock, reset, port
	input wire logic                  irq_req, irq_preempt, int_enter, int_return, // interrupt strobes
	input wire logic                  stack_push, arbitration_nesting, pointer_mode_twin, // state bits
	input wire logic [7:0]            reg_addr, status_flags, stack_pop_flags, stack_push_flags, // bytes
	input wire logic [7:0]            wr_phys_addr, // mapped address
	input wire logic [3:0]            wr_index,     // working register
	input wire logic [2:0]            irq_level, current_prio, nest_depth, // levels
	input wire cfr_pkg::cfr_ptr_cmd_t ptr_cmd       // pointer command
);
	// one clock domain, reset masks every check
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_REJECT:
	assert property (reg_reject == ((reg_wr || reg_rd) && reg_addr[7:4] == 4'hD)) else $error("reject flag wrong");
	AST_RSVD:
	assert property (status_flags[1] == 1'b0) else $error("reserved flag bit set");
	AST_PREEMPT:
	assert property (irq_preempt == (irq_req && irq_level < current_prio
		&& (arbitration_nesting ? nest_depth < 3'h7 : nest_depth == 3'h0))) else $error("preempt wrong");
	// entry saves flags and takes the new level
	AST_ENTER:
	assert property (int_enter && !int_return && nest_depth < 3'h7 |=> stack_push
		&& stack_push_flags == $past(status_flags) && current_prio == $past(irq_level)) else $error("entry wrong");
	AST_RETURN:
	assert property (int_return && !int_enter && nest_depth != 3'h0 |=> nest_depth == $past(nest_depth) - 3'h1
		&& status_flags == ($past(stack_pop_flags) & 8'hFD)) else $error("return wrong");
	AST_CAP:
	assert property (int_enter && !int_return && nest_depth == 3'h7 |=> nest_depth == 3'h7 && !stack_push)
		else $error("depth cap broken");
	AST_SINGLE_MAP:
	assert property (!pointer_mode_twin |-> wr_phys_addr[3:0] == wr_index) else $error("single map wrong");
	AST_TWIN_MAP:
	assert property (pointer_mode_twin |-> wr_phys_addr[2:0] == wr_index[2:0]) else $error("twin map wrong");
	AST_TWIN_SET:
	assert property (ptr_cmd inside {CFR_PTR_LOW, CFR_PTR_HIGH} |=> pointer_mode_twin) else $error("twin not set");
	AST_SINGLE_SET:
	assert property (ptr_cmd == CFR_PTR_SINGLE |=> !pointer_mode_twin) else $error("single not set");
endmodule : cfr_core_regs_assertions

// ==== testbench/cfr_stack_model.sv ====
// ==========================================================
// system stack model holding pushed flag bytes
// assumes pushes and pops never fall in one cycle
`timescale 1ns/100ps
module cfr_stack_model (
	input  wire logic       ref_clk,          // core clock
	input  wire logic       rst,              // synchronous reset
	input  wire logic       stack_push,       // push strobe
	input  wire logic       int_return,       // pop strobe
	input  wire logic [7:0] stack_push_flags, // byte pushed
	output logic      [7:0] stack_pop_flags   // byte popped
);
	logic [7:0] mem [0:7]; // eight slots cover seven nesting levels
	logic [3:0] sp;        // filled slots

	// push on entry, pop on return
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sp <= 4'h0;
		end else if (stack_push) begin
			mem[sp[2:0]] <= stack_push_flags;
			sp <= sp + 4'h1;
		end else if (int_return && sp != 4'h0) begin
			sp <= sp - 4'h1;
		end
	end

	// empty stack shows a changed value, never stale data
	assign stack_pop_flags = (sp == 4'h0) ? ~mem[0] : mem[sp[2:0] - 3'h1];
endmodule : cfr_stack_model

// ==== testbench/test_cfr_core_regs.sv ====
// ==========================================================
// self-checking bench for cfr_core_regs with a stack model
// assumes inputs change 1 ns after each rising edge
`timescale 1ns/100ps
module test_cfr_core_regs;
	import cfr_pkg::*;
	logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, alu_valid = 0, alu_word = 0, alu_carry_b7 = 0;
	logic alu_carry_b15 = 0, alu_half = 0, alu_overflow = 0, alu_sub = 0, carry_set = 0, carry_clr = 0;
	logic carry_inv = 0, space_data = 0, space_prog = 0, irq_req = 0, int_enter = 0, int_return = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, status_flags, stack_pop_flags, stack_push_flags;
	logic [7:0] wr_phys_addr;
	logic [15:0] alu_result = 0;
	logic [4:0] ptr_block = 0;
	logic [3:0] wr_index = 0;
	logic [2:0] irq_level = 0, current_prio, nest_depth;
	logic reg_hit, reg_reject, memory_space_select, irq_preempt, stack_push, arbitration_nesting;
	logic pointer_mode_twin;
	cfr_op_t alu_op = CFR_OP_NONE;
	cfr_ptr_cmd_t ptr_cmd = CFR_PTR_NONE;
	int n_mismatch = 0, tests_run = 0;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end

	cfr_core_regs i_cfr_core_regs (.*);
	cfr_stack_model i_cfr_stack_model (.*);
	always #5 ref_clk = ~ref_clk;

	// ==========================================================
	// access tasks
	task automatic tick(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		tick();
		reg_wr = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1;
		tick();
		reg_rd = 0;
		`CHK("rdata", e, reg_rdata)
	endtask : rd
	// f packs carry15, carry7, half, overflow, subtract
	task automatic alu(input cfr_op_t op, input logic w, input logic [15:0] r, input logic [4:0] f,
		input logic [7:0] e);
		alu_op = op;
		alu_word = w;
		alu_result = r;
		{alu_carry_b15, alu_carry_b7, alu_half, alu_overflow, alu_sub} = f;
		alu_valid = 1;
		tick();
		alu_valid = 0;
		`CHK("flags", e, status_flags)
		tick();
	endtask : alu
	// v packs set, clear, invert, data space, program space
	task automatic ops(input logic [4:0] v, input logic [7:0] e);
		{carry_set, carry_clr, carry_inv, space_data, space_prog} = v;
		tick();
		{carry_set, carry_clr, carry_inv, space_data, space_prog} = 5'h00;
		`CHK("flags", e, status_flags)
		tick();
	endtask : ops
	task automatic ptr(input cfr_ptr_cmd_t c, input logic [4:0] b);
		ptr_cmd = c;
		ptr_block = b;
		tick();
		ptr_cmd = CFR_PTR_NONE;
		tick();
	endtask : ptr
	task automatic map(input logic [3:0] i, input logic [7:0] e);
		wr_index = i;
		#1;
		`CHK("phys", e, wr_phys_addr)
	endtask : map
	task automatic ent(input logic [2:0] l, input logic p);
		irq_level = l;
		int_enter = 1;
		tick();
		int_enter = 0;
		`CHK("push", p, stack_push)
		tick();
	endtask : ent
	task automatic ret();
		int_return = 1;
		tick();
		int_return = 0;
		tick();
	endtask : ret
	task automatic end_of_test();
		if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// ==========================================================
	// main sequence
	initial begin
		tick(2);
		rst = 0;
		`CHK("prio", 3'h7, current_prio)
		rd(8'hE7, 8'h00);
		wr(8'hE6, 8'h0B);
		`CHK("nest", 1'b1, arbitration_nesting)
		rd(8'hE6, 8'h0B);
		wr(8'hE7, 8'hFF);
		rd(8'hE7, 8'hFD);
		wr(8'hE7, 8'h00);
		reg_addr = 8'hD3;
		reg_rd = 1;
		#1;
		`CHK("reject", 1'b1, reg_reject)
		`CHK("hit", 1'b0, reg_hit)
		tick();
		reg_rd = 0;
		`CHK("rdata", 8'h00, reg_rdata)
		alu(CFR_OP_ARITH, 0, 16'h0000, 5'b01101, 8'hCC);
		alu(CFR_OP_ARITH, 1, 16'h8000, 5'b10010, 8'hBC);
		alu(CFR_OP_LOGIC, 0, 16'h0000, 5'b00000, 8'hCC);
		alu(CFR_OP_MULDV, 1, 16'h0001, 5'b00000, 8'h0C);
		alu(CFR_OP_SHIFT, 0, 16'h0080, 5'b01000, 8'hAC);
		ops(5'b01000, 8'h2C);
		ops(5'b10000, 8'hAC);
		ops(5'b00100, 8'h2C);
		ops(5'b00010, 8'h2D);
		`CHK("space", 1'b1, memory_space_select)
		ops(5'b00001, 8'h2C);
		ptr(CFR_PTR_SINGLE, 5'd3);
		map(4'h0, 8'h10);
		map(4'hF, 8'h1F);
		rd(8'hE8, 8'h18);
		`CHK("hit", 1'b1, reg_hit)
		ptr(CFR_PTR_LOW, 5'd5);
		ptr(CFR_PTR_HIGH, 5'd9);
		`CHK("twin", 1'b1, pointer_mode_twin)
		map(4'h2, 8'h2A);
		map(4'hA, 8'h4A);
		rd(8'hE9, 8'h4C);
		ptr(CFR_PTR_LOW, 5'd31);
		map(4'h7, 8'hFF);
		irq_req = 1;
		irq_level = 3'd1;
		#1;
		`CHK("preempt", 1'b1, irq_preempt)
		irq_level = 3'd5;
		#1;
		`CHK("preempt", 1'b0, irq_preempt)
		ent(3'd1, 1'b1);
		`CHK("saved", 8'h2C, stack_push_flags)
		wr(8'hE7, 8'h01);
		ent(3'd0, 1'b1);
		`CHK("depth", 3'd2, nest_depth)
		ret();
		`CHK("flags", 8'h01, status_flags)
		`CHK("prio", 3'd1, current_prio)
		ret();
		`CHK("prio", 3'd3, current_prio)
		for (int i = 0; i < 8; i++) ent(3'd2, i < 7);
		`CHK("depth", 3'd7, nest_depth)
		repeat (7) ret();
		`CHK("prio", 3'd3, current_prio)
		wr(8'hE6, 8'h03);
		`CHK("preempt", 1'b1, irq_preempt)
		ent(3'd2, 1'b1);
		irq_level = 3'd0;
		#1;
		`CHK("preempt", 1'b0, irq_preempt)
		end_of_test();
	end

	// hang guard, well past the expected run
	initial begin
		#5000;
		n_mismatch++;
		end_of_test();
	end
endmodule : test_cfr_core_regs

bind cfr_core_regs cfr_core_regs_assertions i_cfr_core_regs_assertions (.*);
